// >>> rtl/dspwm_cfg.svh
// Register offsets, field positions, codes and reset values for the dual-slope PWM block
`ifndef DSPWM_CFG_SVH
`define DSPWM_CFG_SVH

`define DSPWM_CHANS 3
`define DSPWM_ADDR_W 8
`define DSPWM_WORD_BYTES 8'h04

// Register byte offsets
`define DSPWM_OFS_CTRL 8'h00
`define DSPWM_OFS_COUNT 8'h04
`define DSPWM_OFS_CAPTOP 8'h08
`define DSPWM_OFS_CMPA 8'h0C
`define DSPWM_OFS_CMPB 8'h10
`define DSPWM_OFS_CMPC 8'h14
`define DSPWM_OFS_FLAGS 8'h18
`define DSPWM_OFS_STATUS 8'h1C

// Control register fields
`define DSPWM_CTRL_WGM 3:0
`define DSPWM_CTRL_CS 6:4
`define DSPWM_CTRL_COM_LSB 8
`define DSPWM_COM_W 2
`define DSPWM_CTRL_DDR_LSB 16
`define DSPWM_CTRL_RST 32'h0000_0000

// Flag register bits
`define DSPWM_FLG_OVF 0
`define DSPWM_FLG_CMP_LSB 1
`define DSPWM_FLG_CAP 4
`define DSPWM_FLG_W 5
`define DSPWM_FLG_RST 5'h00

// Waveform mode selector values
`define DSPWM_WGM_CAP_TOP 4'h8
`define DSPWM_WGM_CMPA_TOP 4'h9

// Output mode selector values
`define DSPWM_COM_OFF 2'h0
`define DSPWM_COM_TOGGLE 2'h1
`define DSPWM_COM_NONINV 2'h2
`define DSPWM_COM_INV 2'h3

// Clock select codes and divider masks
`define DSPWM_CS_DIV1 3'h1
`define DSPWM_CS_DIV8 3'h2
`define DSPWM_CS_DIV64 3'h3
`define DSPWM_CS_DIV256 3'h4
`define DSPWM_CS_DIV1024 3'h5
`define DSPWM_PRE_W 10
`define DSPWM_MASK_DIV8 10'h007
`define DSPWM_MASK_DIV64 10'h03F
`define DSPWM_MASK_DIV256 10'h0FF
`define DSPWM_MASK_DIV1024 10'h3FF

`define DSPWM_CNT_W 16
`define DSPWM_CNT_ZERO 16'h0000
`define DSPWM_CNT_ONE 16'h0001

`define DSPWM_RESP_OKAY 2'h0
`define DSPWM_RESP_SLVERR 2'h2

`endif

// >>> rtl/dspwm_pkg.sv
// Types shared by the dual-slope PWM block
package dspwm_pkg;
  typedef enum logic [0:0] {
    dir_up = 1'b0,
    dir_down = 1'b1
  } dspwm_dir_e;
endpackage

// >>> rtl/dspwm_prescale.sv
// Timer tick enable divider for the dual-slope PWM block
`timescale 1ns/1ns
`include "dspwm_cfg.svh"

module dspwm_prescale (
  input wire logic aclk,       // System clock
  input wire logic aresetn,    // Synchronous reset, active low
  input wire logic [2:0] clk_sel, // Divider select
  output logic timer_tick_enable // One-cycle tick pulse
);

  logic [`DSPWM_PRE_W-1:0] pre_count;
  logic [`DSPWM_PRE_W-1:0] mask;

  // Free-running so every divider stays aligned to the same phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_count <= '0;
    end else begin
      pre_count <= pre_count + 1'b1;
    end
  end

  always_comb begin
    case (clk_sel)
      `DSPWM_CS_DIV8: mask = `DSPWM_MASK_DIV8;
      `DSPWM_CS_DIV64: mask = `DSPWM_MASK_DIV64;
      `DSPWM_CS_DIV256: mask = `DSPWM_MASK_DIV256;
      `DSPWM_CS_DIV1024: mask = `DSPWM_MASK_DIV1024;
      default: mask = '0;
    endcase
  end

  always_comb begin
    case (clk_sel)
      `DSPWM_CS_DIV1: timer_tick_enable = 1'b1;
      `DSPWM_CS_DIV8, `DSPWM_CS_DIV64, `DSPWM_CS_DIV256, `DSPWM_CS_DIV1024: begin
        timer_tick_enable = ((pre_count & mask) == mask);
      end
      default: timer_tick_enable = 1'b0;
    endcase
  end

endmodule // dspwm_prescale

// >>> rtl/dspwm_top.sv
// Dual-slope phase and frequency correct PWM timer with AXI4-Lite registers
// Function
// - PWM operation runs when waveform mode selector is 8 or 9.
// - Counter runs zero up to top, then back down to zero, repeatedly.
// - Non-inverting clears on up-count match, sets on down-count match; inverting opposite.
// - Top comes from capture register in mode 8, compare A in mode 9.
// - Counter holds top value for exactly one timer tick before counting down.
// - Compare match flag sets on each PWM-mode timer tick where counter equals channel compare value.
// - Overflow flag sets in the tick the compare buffers load, at bottom.
// - Compare A or capture flag sets when counter reaches top it defines.
// - Active compare values load from buffers only at bottom of count.
// - Output mode two gives non-inverted PWM, three gives inverted PWM.
// - Waveform reaches pin only when pin direction bit selects output.
// - Compare zero holds output low, compare top high; inverted gives opposite.
// - Mode 9 with channel A output mode 1 toggles A on match.
// - All logic on the system clock, counting only on timer ticks.
// - Timer tick divides system clock by 1, 8, 64, 256 or 1024.
// - Compare writes go to a buffer, active value changes at update point.
// - Output mode 0 disconnects waveform, leaving pin under normal port control.
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "dspwm_cfg.svh"

module dspwm_top (
  input wire logic aclk,                        // System clock, 100 MHz
  input wire logic aresetn,                     // Synchronous reset, active low
  input wire logic [`DSPWM_ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot,          // Write protection, unused
  input wire logic s_axi_awvalid,               // Write address valid
  output logic s_axi_awready,                   // Write address ready
  input wire logic [31:0] s_axi_wdata,          // Write data
  input wire logic [3:0] s_axi_wstrb,           // Write byte strobes
  input wire logic s_axi_wvalid,                // Write data valid
  output logic s_axi_wready,                    // Write data ready
  output logic [1:0] s_axi_bresp,               // Write response
  output logic s_axi_bvalid,                    // Write response valid
  input wire logic s_axi_bready,                // Write response ready
  input wire logic [`DSPWM_ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot,          // Read protection, unused
  input wire logic s_axi_arvalid,               // Read address valid
  output logic s_axi_arready,                   // Read address ready
  output logic [31:0] s_axi_rdata,              // Read data
  output logic [1:0] s_axi_rresp,               // Read response
  output logic s_axi_rvalid,                    // Read data valid
  input wire logic s_axi_rready,                // Read data ready
  input wire logic [`DSPWM_CHANS-1:0] port_data, // Normal port output levels
  output logic [`DSPWM_CHANS-1:0] wave_output,  // Raw compare waveforms
  output logic [`DSPWM_CHANS-1:0] pin_out,      // Pin output level
  output logic [`DSPWM_CHANS-1:0] pin_oe_n,     // Pin output enable, active low
  output logic [`DSPWM_CNT_W-1:0] count_value   // Current counter value
);

  // Register state
  logic [31:0] ctrl;
  logic [`DSPWM_CNT_W-1:0] capture_top_value;
  logic [`DSPWM_CHANS-1:0][`DSPWM_CNT_W-1:0] cmp_buf;
  logic [`DSPWM_CHANS-1:0][`DSPWM_CNT_W-1:0] cmp_act;
  logic [`DSPWM_FLG_W-1:0] flags;
  dspwm_pkg::dspwm_dir_e dir;

  // Bus state
  logic aw_held;
  logic w_held;
  logic [`DSPWM_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] rd_mux;
  logic rd_hit;

  // Decoded control
  logic [3:0] waveform_mode_sel;
  logic [`DSPWM_CHANS-1:0][`DSPWM_COM_W-1:0] output_mode_sel;
  logic [`DSPWM_CHANS-1:0] pin_direction_bit;
  logic timer_tick_enable;

  // Counter events
  logic pfc_mode;
  logic mode_cmpa_top;
  logic [`DSPWM_CNT_W-1:0] top_value;
  logic step;
  logic at_bottom;
  logic at_top;
  logic slope_up;
  logic [`DSPWM_CHANS-1:0] match;
  logic [`DSPWM_FLG_W-1:0] flag_set;
  logic [`DSPWM_FLG_W-1:0] flag_clr;

  assign waveform_mode_sel = ctrl[`DSPWM_CTRL_WGM];
  assign pfc_mode = (waveform_mode_sel == `DSPWM_WGM_CAP_TOP) ||
                    (waveform_mode_sel == `DSPWM_WGM_CMPA_TOP);
  assign mode_cmpa_top = (waveform_mode_sel == `DSPWM_WGM_CMPA_TOP);
  assign top_value = mode_cmpa_top ? cmp_act[0] : capture_top_value;
  assign step = timer_tick_enable && pfc_mode;
  assign at_bottom = (count_value == `DSPWM_CNT_ZERO);
  assign at_top = (dir == dspwm_pkg::dir_up) && (count_value >= top_value);
  // Bottom acts as up-slope, top as down-slope, so extreme compare values give steady levels
  assign slope_up = at_bottom || ((dir == dspwm_pkg::dir_up) && !at_top);

  dspwm_prescale u_prescale (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_sel(ctrl[`DSPWM_CTRL_CS]),
    .timer_tick_enable(timer_tick_enable)
  );

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    case (aw_addr)
      `DSPWM_OFS_CTRL, `DSPWM_OFS_COUNT, `DSPWM_OFS_CAPTOP, `DSPWM_OFS_CMPA, `DSPWM_OFS_CMPB,
      `DSPWM_OFS_CMPC, `DSPWM_OFS_FLAGS, `DSPWM_OFS_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DSPWM_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `DSPWM_RESP_OKAY : `DSPWM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register, byte-lane writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `DSPWM_CTRL_RST;
    end else if (wr_fire && aw_addr == `DSPWM_OFS_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb[b]) begin
          ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
        end
      end
    end
  end

  // Capture register is not buffered: a new top takes effect at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_top_value <= `DSPWM_CNT_ZERO;
    end else if (wr_fire && aw_addr == `DSPWM_OFS_CAPTOP) begin
      if (w_strb[0]) begin
        capture_top_value[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        capture_top_value[15:8] <= w_data[15:8];
      end
    end
  end

  // Dual-slope counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value <= `DSPWM_CNT_ZERO;
      dir <= dspwm_pkg::dir_up;
    end else if (step) begin
      if (at_bottom) begin
        count_value <= `DSPWM_CNT_ONE;
        dir <= dspwm_pkg::dir_up;
      end else if (at_top) begin
        // Top stays on the counter for just this tick
        count_value <= count_value - `DSPWM_CNT_ONE;
        dir <= dspwm_pkg::dir_down;
      end else if (dir == dspwm_pkg::dir_up) begin
        count_value <= count_value + `DSPWM_CNT_ONE;
      end else begin
        count_value <= count_value - `DSPWM_CNT_ONE;
      end
    end
  end

  // Per-channel compare, buffer and waveform logic
  for (genvar i = 0; i < `DSPWM_CHANS; i++) begin : g_chan
    localparam logic [`DSPWM_ADDR_W-1:0] CmpOfs =
      `DSPWM_OFS_CMPA + `DSPWM_ADDR_W'(i) * `DSPWM_WORD_BYTES;
    logic connected;

    assign output_mode_sel[i] = ctrl[`DSPWM_CTRL_COM_LSB + i*`DSPWM_COM_W +: `DSPWM_COM_W];
    assign pin_direction_bit[i] = ctrl[`DSPWM_CTRL_DDR_LSB + i];
    // A mismatched top means this never fires for that channel
    assign match[i] = step && (count_value == cmp_act[i]);
    assign connected = (output_mode_sel[i] == `DSPWM_COM_NONINV) ||
                       (output_mode_sel[i] == `DSPWM_COM_INV) ||
                       ((output_mode_sel[i] == `DSPWM_COM_TOGGLE) && (i == 0) && mode_cmpa_top);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cmp_buf[i] <= `DSPWM_CNT_ZERO;
      end else if (wr_fire && aw_addr == CmpOfs) begin
        if (w_strb[0]) begin
          cmp_buf[i][7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          cmp_buf[i][15:8] <= w_data[15:8];
        end
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cmp_act[i] <= `DSPWM_CNT_ZERO;
      end else if (step && at_bottom) begin
        cmp_act[i] <= cmp_buf[i];
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wave_output[i] <= 1'b0;
      end else if (match[i]) begin
        case (output_mode_sel[i])
          `DSPWM_COM_NONINV: wave_output[i] <= !slope_up;
          `DSPWM_COM_INV: wave_output[i] <= slope_up;
          `DSPWM_COM_TOGGLE: begin
            if (i == 0 && mode_cmpa_top) begin
              wave_output[i] <= !wave_output[i];
            end
          end
          default: wave_output[i] <= wave_output[i];
        endcase
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_out[i] <= 1'b0;
        pin_oe_n[i] <= 1'b1;
      end else begin
        pin_out[i] <= connected ? wave_output[i] : port_data[i];
        pin_oe_n[i] <= !pin_direction_bit[i];
      end
    end
  end

  // Flags: hardware set wins over a same-cycle write-one clear
  always_comb begin
    flag_set = '0;
    flag_set[`DSPWM_FLG_OVF] = step && at_bottom;
    flag_set[`DSPWM_FLG_CMP_LSB +: `DSPWM_CHANS] = match;
    if (step && count_value == top_value && dir == dspwm_pkg::dir_up) begin
      if (mode_cmpa_top) begin
        flag_set[`DSPWM_FLG_CMP_LSB] = 1'b1;
      end else begin
        flag_set[`DSPWM_FLG_CAP] = 1'b1;
      end
    end
  end

  always_comb begin
    flag_clr = '0;
    if (wr_fire && aw_addr == `DSPWM_OFS_FLAGS && w_strb[0]) begin
      flag_clr = w_data[`DSPWM_FLG_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= `DSPWM_FLG_RST;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // AXI4-Lite read, one cycle from address to data
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `DSPWM_OFS_CTRL: rd_mux = ctrl;
      `DSPWM_OFS_COUNT: rd_mux[`DSPWM_CNT_W-1:0] = count_value;
      `DSPWM_OFS_CAPTOP: rd_mux[`DSPWM_CNT_W-1:0] = capture_top_value;
      `DSPWM_OFS_CMPA: rd_mux[`DSPWM_CNT_W-1:0] = cmp_buf[0];
      `DSPWM_OFS_CMPB: rd_mux[`DSPWM_CNT_W-1:0] = cmp_buf[1];
      `DSPWM_OFS_CMPC: rd_mux[`DSPWM_CNT_W-1:0] = cmp_buf[2];
      `DSPWM_OFS_FLAGS: rd_mux[`DSPWM_FLG_W-1:0] = flags;
      `DSPWM_OFS_STATUS: rd_mux[0] = (dir == dspwm_pkg::dir_down);
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `DSPWM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? `DSPWM_RESP_OKAY : `DSPWM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // dspwm_top

// >>> tb/dspwm_load.sv
// Pin load model for the dual-slope PWM block: pulled-down pins, high-time counters
`timescale 1ns/1ns

module dspwm_load (
  input wire logic aclk, // System clock
  input wire logic clr, // Restart the counters
  input wire logic [2:0] pin_out, // Pin level offered
  input wire logic [2:0] pin_oe_n, // Pin driver enable, active low
  output logic [2:0][15:0] hi_cnt // High cycles seen per pin
);
  logic [2:0] lvl;

  // Released pin falls to the pull-down, never keeps the last value
  assign lvl = pin_out & ~pin_oe_n;

  always_ff @(posedge aclk) begin
    for (int i = 0; i < 3; i++) begin
      hi_cnt[i] <= clr ? 16'h0000 : hi_cnt[i] + {15'h0000, lvl[i]};
    end
  end
endmodule // dspwm_load

// >>> tb/dspwm_top_chk.sv
// Port-level assertion checker for the dual-slope PWM block
`timescale 1ns/1ns
`include "dspwm_cfg.svh"

module dspwm_top_chk (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Reset, active low
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic [`DSPWM_CHANS-1:0] port_data, // Normal port levels
  input wire logic [`DSPWM_CHANS-1:0] wave_output, // Raw waveforms
  input wire logic [`DSPWM_CHANS-1:0] pin_out, // Pin levels
  input wire logic [`DSPWM_CHANS-1:0] pin_oe_n, // Pin enables, active low
  input wire logic [`DSPWM_CNT_W-1:0] count_value // Counter
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_state: assert property (
    $rose(aresetn) |-> count_value == 16'h0000 && wave_output == 3'h0 && pin_oe_n == 3'h7)
    else $error("counter or outputs not cleared after reset");
  a_bottom_turn: assert property (
    $past(count_value) == 16'h0000 && count_value != 16'h0000 |-> count_value == 16'h0001)
    else $error("counter left bottom other than upward by one");
  a_count_step: assert property (
    count_value != $past(count_value) |->
      count_value - $past(count_value) == 16'h0001 || $past(count_value) - count_value == 16'h0001)
    else $error("counter moved by more than one");
  a_pin_source: assert property (
    ((pin_out ^ $past(wave_output)) & (pin_out ^ $past(port_data))) == 3'h0)
    else $error("pin level from neither waveform nor port");
  a_oe_on_write: assert property (
    pin_oe_n != $past(pin_oe_n) |-> $past(s_axi_bvalid))
    else $error("pin enable changed without a register write");
  a_write_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while read data pending");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while write response pending");
endmodule // dspwm_top_chk

bind dspwm_top dspwm_top_chk dspwm_top_chk_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .port_data, .wave_output, .pin_out, .pin_oe_n, .count_value);

// >>> tb/dspwm_top_tb.sv
// Self-checking testbench for the dual-slope PWM block
`timescale 1ns/1ns
`include "dspwm_cfg.svh"

module dspwm_top_tb;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [2:0] port_data = 3'h0;
  logic clr = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic [31:0] s_axi_rdata, rd_data;
  logic [2:0] wave_output, pin_out, pin_oe_n;
  logic [15:0] count_value;
  logic [2:0][15:0] hi_cnt;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;

  always #5 aclk = ~aclk;

  dspwm_top dspwm_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_data,
    .wave_output, .pin_out, .pin_oe_n, .count_value);

  dspwm_load dspwm_load_inst (.aclk, .clr, .pin_out, .pin_oe_n, .hi_cnt);

  // Control word; com packs output modes C, B, A
  function automatic logic [31:0] ctl(logic [3:0] m, logic [2:0] cs, logic [5:0] com, logic [2:0] ddr);
    return {13'h0000, ddr, 2'h0, com, 1'h0, cs, m};
  endfunction

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    logic ta;
    logic tw;
    aw = 1'h1;
    w = 1'h1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // Readies are sampled mid-cycle, where they are settled
    while (aw || w) begin
      @(negedge aclk);
      ta = aw & s_axi_awready;
      tw = w & s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      aw = aw & ~ta;
      w = w & ~tw;
    end
    do begin
      @(negedge aclk);
      ta = s_axi_bvalid;
      wr_resp = s_axi_bresp;
      @(posedge aclk);
    end while (!ta);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 1'h0;
    do begin
      @(negedge aclk);
      t = s_axi_rvalid;
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      @(posedge aclk);
    end while (!t);
    s_axi_rready <= 1'h0;
  endtask

  task automatic wait_cnt(input logic [15:0] v);
    do @(negedge aclk); while (count_value !== v);
  endtask

  task automatic meas(input int n);
    @(posedge aclk);
    clr <= 1'h1;
    @(posedge aclk);
    clr <= 1'h0;
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic t_reset;
    chk(32'(count_value), 32'h0000_0000);
    chk(32'({wave_output, pin_oe_n}), 32'h0000_0007);
    rd(`DSPWM_OFS_FLAGS);
    chk(rd_data, 32'h0000_0000);
    rd(8'h20);
    chk({rd_data[29:0], rd_resp}, {30'h0000_0000, `DSPWM_RESP_SLVERR});
    wr(8'h20, 32'h0000_0000);
    chk(32'(wr_resp), 32'(`DSPWM_RESP_SLVERR));
    rd(`DSPWM_OFS_STATUS);
    chk(rd_data, 32'h0000_0000);
  endtask

  task automatic t_mode9;
    port_data <= 3'h2;
    wr(`DSPWM_OFS_CMPA, 32'h0000_0004);
    chk(32'(wr_resp), 32'(`DSPWM_RESP_OKAY));
    wr(`DSPWM_OFS_CMPB, 32'h0000_0006);
    wr(`DSPWM_OFS_CMPC, 32'h0000_0000);
    wr(`DSPWM_OFS_CTRL, ctl(`DSPWM_WGM_CMPA_TOP, `DSPWM_CS_DIV1, 6'h01, 3'h7));
    wait_cnt(16'h0004);
    wait_cnt(16'h0000);
    wr(`DSPWM_OFS_FLAGS, 32'h0000_001F);
    repeat (16) @(posedge aclk);
    rd(`DSPWM_OFS_FLAGS);
    chk(rd_data, 32'h0000_000B);
    meas(64);
    chk(32'(hi_cnt[0]), 32'h0000_0020);
    chk(32'(hi_cnt[1]), 32'h0000_0040);
    chk(32'(hi_cnt[2]), 32'h0000_0000);
  endtask

  task automatic t_mode8;
    wr(`DSPWM_OFS_CAPTOP, 32'h0000_0004);
    wr(`DSPWM_OFS_CMPA, 32'h0000_0001);
    wr(`DSPWM_OFS_CMPB, 32'h0000_0000);
    wr(`DSPWM_OFS_CMPC, 32'h0000_0004);
    wr(`DSPWM_OFS_CTRL, ctl(`DSPWM_WGM_CAP_TOP, `DSPWM_CS_DIV1, 6'h2E, 3'h7));
    wait_cnt(16'h0004);
    wait_cnt(16'h0000);
    for (int i = 0; i < 16; i++) begin
      chk(32'(count_value), 32'((i % 8 <= 4) ? i % 8 : 8 - i % 8));
      @(negedge aclk);
    end
    meas(64);
    chk(32'(hi_cnt[0]), 32'h0000_0010);
    chk(32'(hi_cnt[1]), 32'h0000_0040);
    chk(32'(hi_cnt[2]), 32'h0000_0040);
    wr(`DSPWM_OFS_FLAGS, 32'h0000_001F);
    repeat (16) @(posedge aclk);
    rd(`DSPWM_OFS_FLAGS);
    chk(rd_data, 32'h0000_001F);
  endtask

  task automatic t_buffer;
    wr(`DSPWM_OFS_CAPTOP, 32'h0000_0064);
    wr(`DSPWM_OFS_CMPA, 32'h0000_0032);
    wr(`DSPWM_OFS_CTRL, ctl(`DSPWM_WGM_CAP_TOP, `DSPWM_CS_DIV1, 6'h02, 3'h7));
    wait_cnt(16'h0000);
    wait_cnt(16'h0064);
    wait_cnt(16'h0000);
    wait_cnt(16'h0014);
    // Raise compare mid up-slope; old value must rule until bottom
    wr(`DSPWM_OFS_CMPA, 32'h0000_0050);
    rd(`DSPWM_OFS_CMPA);
    chk(rd_data, 32'h0000_0050);
    wait_cnt(16'h003C);
    chk(32'(wave_output[0]), 32'h0000_0000);
    rd(`DSPWM_OFS_STATUS);
    chk(rd_data, 32'h0000_0000);
    wait_cnt(16'h0064);
    wait_cnt(16'h003C);
    chk(32'(wave_output[0]), 32'h0000_0000);
    rd(`DSPWM_OFS_STATUS);
    chk(rd_data, 32'h0000_0001);
    wait_cnt(16'h0000);
    wait_cnt(16'h003C);
    chk(32'(wave_output[0]), 32'h0000_0001);
  endtask

  task automatic t_clock;
    logic [15:0] v;
    int n;
    int div [5] = '{1, 8, 64, 256, 1024};
    for (int j = 0; j < 5; j++) begin
      wr(`DSPWM_OFS_CTRL, ctl(`DSPWM_WGM_CAP_TOP, 3'(j + 1), 6'h00, 3'h0));
      @(negedge aclk);
      v = count_value;
      do @(negedge aclk); while (count_value === v);
      v = count_value;
      n = 0;
      do begin
        @(negedge aclk);
        n++;
      end while (count_value === v);
      chk(32'(n), 32'(div[j]));
    end
    chk(32'(pin_oe_n), 32'h0000_0007);
    for (int k = 0; k < 2; k++) begin
      wr(`DSPWM_OFS_CTRL, ctl(k ? 4'h0 : `DSPWM_WGM_CAP_TOP, k ? `DSPWM_CS_DIV1 : 3'h0, 6'h00, 3'h0));
      @(negedge aclk);
      v = count_value;
      repeat (40) @(negedge aclk);
      chk(32'(count_value), 32'(v));
    end
  endtask

  // Longest legal run is well under this many cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("[FAIL] %0t run did not finish in time", $time);
      give_verdict;
    end
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    t_reset;
    t_mode9;
    t_mode8;
    t_buffer;
    t_clock;
    give_verdict;
  end
endmodule // dspwm_top_tb
